// File: sbb_link_engine.sv
`timescale 1ns/1ps
`default_nettype none
module sbb_link_engine (
  input wire logic clk_link,
  input wire logic reset,
  input wire logic req_tgl,
  input wire logic [7:0] op_target,
  input wire logic [7:0] op_index,
  input wire logic [7:0] op_data,
  input wire logic op_short,
  input wire logic op_test,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  output logic done_tgl,
  output logic link_err,
  output logic [7:0] link_rdata
);
  import sbb_pkg::*;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic test_s1;
    logic test_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    sbb_step_t step;
    logic [4:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] addr;
    logic [7:0] index;
    logic [7:0] wdata;
    logic short_sel;
    logic scl_o;
    logic sda_o;
    logic err;
    logic [7:0] rdata;
    logic done_tgl;
  } sbb_eng_st_t;

  sbb_eng_st_t st_reg;
  sbb_eng_st_t st_next;

  // ==========================================================
  // sequencer
  always_comb begin
    logic sending;
    logic [4:0] qlim;
    sbb_step_t nxt;
    logic [7:0] nbyte;
    st_next = st_reg;
    sending = (st_reg.step != SBB_RDATA);
    qlim = st_reg.test_s2 ? SBB_QTR_LIM_TEST : SBB_QTR_LIM;
    nxt = SBB_STOP;
    nbyte = 8'h00;
    st_next.rst_s1 = reset;
    st_next.rst_s2 = st_reg.rst_s1;
    st_next.req_s1 = req_tgl;
    st_next.req_s2 = st_reg.req_s1;
    st_next.test_s1 = op_test;
    st_next.test_s2 = st_reg.test_s1;
    st_next.scl_s1 = scl_in;
    st_next.scl_s2 = st_reg.scl_s1;
    st_next.sda_s1 = sda_in;
    st_next.sda_s2 = st_reg.sda_s1;
    if (st_reg.step == SBB_IDLE) begin
      if (st_reg.req_s2 != st_reg.req_seen) begin
        st_next.req_seen = st_reg.req_s2;
        st_next.addr = op_target;
        st_next.index = op_index;
        st_next.wdata = op_data;
        st_next.short_sel = op_short;
        st_next.err = 1'b0;
        st_next.step = SBB_START;
        st_next.phase = 2'h0;
        st_next.qcnt = qlim;
      end
    end else if (st_reg.qcnt != 5'h00) begin
      st_next.qcnt = st_reg.qcnt - 5'h01;
    end else if (!(st_reg.phase == 2'h1 && !st_reg.scl_s2)) begin
      // a held-low clock in the high quarter is stretching by the target
      st_next.qcnt = qlim;
      st_next.phase = st_reg.phase + 2'h1;
      case (st_reg.phase)
        2'h0: begin
          st_next.scl_o = 1'b1;
        end
        2'h1: begin
          if (st_reg.step == SBB_START || st_reg.step == SBB_RESTART) begin
            st_next.sda_o = 1'b0;
          end else if (st_reg.step == SBB_STOP) begin
            st_next.sda_o = 1'b1;
          end else if (st_reg.bitn == SBB_ACK_BIT) begin
            if (sending && st_reg.sda_s2) begin
              st_next.err = 1'b1;
            end
          end else if (!sending) begin
            st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
          end
        end
        2'h2: begin
          if (st_reg.step != SBB_STOP) begin
            st_next.scl_o = 1'b0;
          end
        end
        default: begin
          if (st_reg.step inside {SBB_ADDR, SBB_INDEX, SBB_ADDR_RD,
                                  SBB_WDATA, SBB_RDATA}
              && st_reg.bitn != SBB_ACK_BIT) begin
            st_next.bitn = st_reg.bitn + 4'h1;
            st_next.shift = sending ? {st_reg.shift[6:0], 1'b0}
                                    : st_next.shift;
            st_next.sda_o = (st_reg.bitn == 4'h7 || !sending) ? 1'b1
                                                              : st_reg.shift[6];
          end else begin
            case (st_reg.step)
              SBB_START: begin
                nxt = SBB_ADDR;
                nbyte = {st_reg.addr[7:1],
                         st_reg.short_sel & st_reg.addr[SBB_TA_DIR]};
              end
              SBB_ADDR: begin
                if (st_next.err) begin
                  nxt = SBB_STOP;
                end else if (st_reg.short_sel) begin
                  nxt = st_reg.addr[SBB_TA_DIR] ? SBB_RDATA : SBB_WDATA;
                end else begin
                  nxt = SBB_INDEX;
                end
                nbyte = st_reg.short_sel ? st_reg.wdata : st_reg.index;
              end
              SBB_INDEX: begin
                nxt = st_next.err ? SBB_STOP
                    : (st_reg.addr[SBB_TA_DIR] ? SBB_RESTART : SBB_WDATA);
                nbyte = st_reg.wdata;
              end
              SBB_RESTART: begin
                nxt = SBB_ADDR_RD;
                nbyte = {st_reg.addr[7:1], 1'b1};
              end
              SBB_ADDR_RD: begin
                nxt = st_next.err ? SBB_STOP : SBB_RDATA;
              end
              SBB_RDATA: begin
                st_next.rdata = st_reg.shift;
              end
              SBB_STOP: begin
                nxt = SBB_IDLE;
                st_next.done_tgl = ~st_reg.done_tgl;
              end
              default: begin
                nxt = SBB_STOP;
              end
            endcase
            st_next.step = nxt;
            st_next.bitn = 4'h0;
            st_next.shift = (nxt == SBB_RDATA) ? 8'h00 : nbyte;
            case (nxt)
              SBB_STOP: st_next.sda_o = 1'b0;
              SBB_IDLE: st_next.sda_o = 1'b1;
              SBB_RDATA: st_next.sda_o = 1'b1;
              SBB_RESTART: st_next.sda_o = 1'b1;
              default: st_next.sda_o = nbyte[7];
            endcase
          end
        end
      endcase
    end
    if (st_reg.rst_s2) begin
      st_next = '0;
      st_next.rst_s1 = reset;
      st_next.rst_s2 = st_reg.rst_s1;
      st_next.step = SBB_IDLE;
      st_next.scl_o = 1'b1;
      st_next.sda_o = 1'b1;
    end
  end

  always_ff @(posedge clk_link) begin
    st_reg <= st_next;
  end

  assign scl_out = st_reg.scl_o;
  assign scl_oe_n = st_reg.scl_o;
  assign sda_out = st_reg.sda_o;
  assign sda_oe_n = st_reg.sda_o;
  assign done_tgl = st_reg.done_tgl;
  assign link_err = st_reg.err;
  assign link_rdata = st_reg.rdata;

  // ==========================================================
  // checks
  a_addr_byte: assert property (@(posedge clk_link) disable iff (st_reg.rst_s2)
    (st_reg.step == SBB_ADDR && $past(st_reg.step) == SBB_START)
    |-> st_reg.shift == {st_reg.addr[7:1],
                         st_reg.short_sel & st_reg.addr[0]})
    else $error("address byte not loaded from target register");
  a_short_no_index: assert property (@(posedge clk_link) disable iff (st_reg.rst_s2)
    st_reg.short_sel |-> st_reg.step != SBB_INDEX)
    else $error("index byte sent in short protocol");
  a_index_byte: assert property (@(posedge clk_link) disable iff (st_reg.rst_s2)
    (st_reg.step == SBB_INDEX && $past(st_reg.step) == SBB_ADDR)
    |-> st_reg.shift == st_reg.index)
    else $error("index byte not loaded");
  a_read_restart: assert property (@(posedge clk_link) disable iff (st_reg.rst_s2)
    (st_reg.step == SBB_ADDR_RD && $past(st_reg.step) == SBB_RESTART)
    |-> st_reg.shift[0] && !st_reg.short_sel)
    else $error("read address after restart lacks read direction");
endmodule : sbb_link_engine
`default_nettype wire

// File: sbb_pkg.sv
package sbb_pkg;
  // ==========================================================
  // configuration space map
  localparam logic [2:0] SBB_FUNC_OWN = 3'h0;
  localparam logic [7:0] SBB_OFS_DATA = 8'hB0;
  localparam logic [7:0] SBB_OFS_INDEX = 8'hB1;
  localparam logic [7:0] SBB_OFS_TARGET = 8'hB2;
  localparam logic [7:0] SBB_OFS_CTRL = 8'hB3;
  localparam logic [7:0] SBB_RST_BYTE = 8'h00;
  // ==========================================================
  // control/status field positions
  localparam int SBB_CS_SHORT = 7;
  localparam int SBB_CS_BUSY = 5;
  localparam int SBB_CS_DETECT = 3;
  localparam int SBB_CS_TEST = 2;
  localparam int SBB_CS_ERR = 1;
  localparam int SBB_TA_DIR = 0;
  // ==========================================================
  // serial clock timing
  localparam int SBB_LINK_PERIOD_NS = 160;
  localparam int SBB_SCL_FREQ_KHZ = 100;
  localparam int SBB_TEST_SPEEDUP = 4;
  localparam int SBB_QTR_CYC =
    1000000 / (SBB_LINK_PERIOD_NS * 4 * SBB_SCL_FREQ_KHZ);
  localparam logic [4:0] SBB_QTR_LIM = 5'(SBB_QTR_CYC - 1);
  localparam logic [4:0] SBB_QTR_LIM_TEST =
    5'(SBB_QTR_CYC / SBB_TEST_SPEEDUP - 1);
  localparam logic [3:0] SBB_ACK_BIT = 4'h8;
  localparam logic [1:0] SBB_DET_WAIT = 2'h3;
  localparam logic [5:0] SBB_LINK_RST_LIM = 6'h3F;
  // ==========================================================
  // serial sequencer steps
  typedef enum logic [3:0] {
    SBB_IDLE = 4'b0000,
    SBB_START = 4'b0001,
    SBB_ADDR = 4'b0010,
    SBB_INDEX = 4'b0011,
    SBB_RESTART = 4'b0100,
    SBB_ADDR_RD = 4'b0101,
    SBB_WDATA = 4'b0110,
    SBB_RDATA = 4'b0111,
    SBB_STOP = 4'b1000
  } sbb_step_t;
endpackage : sbb_pkg

// File: sbb_serial_byte_access.sv
// Contract
// - read: poll busy; data valid after clear.
// - target bits 7-1 sent as device address.
// - target bit 0 is the direction bit.
// - full index byte sent as offset.
// - send data byte; load received byte back.
// - registers cleared to zero by global reset.
// - registers only in function 0 at B0-B3.
// - target write launches transfer, sets busy.
// - sticky error on missing acknowledge, write-1 clears.
// - short protocol omits the index byte.
`timescale 1ns/1ps
`default_nettype none
module sbb_serial_byte_access (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_link,
  input wire logic [2:0] cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  import sbb_pkg::*;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] index;
    logic [7:0] target;
    logic short_sel;
    logic detect;
    logic test;
    logic err;
    logic busy;
    logic req_tgl;
    logic done_s1;
    logic done_s2;
    logic done_seen;
    logic scl_s1;
    logic scl_s2;
    logic [1:0] det_cnt;
    logic link_up;
    logic [5:0] lrst_cnt;
    logic [7:0] rdata;
  } sbb_sys_st_t;

  sbb_sys_st_t st_reg;
  sbb_sys_st_t st_next;
  logic eng_done_tgl;
  logic eng_err;
  logic [7:0] eng_rdata;
  logic wr_own;
  logic done_evt;
  logic link_rst;

  assign wr_own = cfg_wr_en && cfg_func == SBB_FUNC_OWN;
  assign done_evt = st_reg.link_up && st_reg.done_s2 != st_reg.done_seen;
  assign link_rst = !st_reg.link_up;

  // ==========================================================
  // register file and request handshake
  always_comb begin
    st_next = st_reg;
    st_next.done_s1 = eng_done_tgl;
    st_next.done_s2 = st_reg.done_s1;
    st_next.scl_s1 = scl_in;
    st_next.scl_s2 = st_reg.scl_s1;
    // keep the slow link engine in reset for several of its clocks
    if (!st_reg.link_up) begin
      st_next.lrst_cnt = st_reg.lrst_cnt + 6'h01;
      if (st_reg.lrst_cnt == SBB_LINK_RST_LIM) begin
        st_next.link_up = 1'b1;
      end
    end
    // pull-up on the clock line marks a bus present after reset
    if (st_reg.link_up && st_reg.det_cnt != SBB_DET_WAIT) begin
      st_next.det_cnt = st_reg.det_cnt + 2'h1;
      if (st_next.det_cnt == SBB_DET_WAIT) begin
        st_next.detect = st_reg.scl_s2;
      end
    end
    if (wr_own) begin
      case (cfg_addr)
        // operands are frozen while a transfer is running
        SBB_OFS_DATA: begin
          if (!st_reg.busy) st_next.data = cfg_wdata;
        end
        SBB_OFS_INDEX: begin
          if (!st_reg.busy) st_next.index = cfg_wdata;
        end
        SBB_OFS_TARGET: begin
          if (!st_reg.busy) begin
            st_next.target = cfg_wdata;
            st_next.busy = 1'b1;
            st_next.req_tgl = ~st_reg.req_tgl;
          end
        end
        SBB_OFS_CTRL: begin
          st_next.short_sel = cfg_wdata[SBB_CS_SHORT];
          st_next.detect = cfg_wdata[SBB_CS_DETECT];
          st_next.test = cfg_wdata[SBB_CS_TEST];
          if (cfg_wdata[SBB_CS_ERR]) st_next.err = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // completion comes after the clear so a new error wins
    if (done_evt) begin
      st_next.done_seen = st_reg.done_s2;
      st_next.busy = 1'b0;
      if (eng_err) begin
        st_next.err = 1'b1;
      end else if (st_reg.target[SBB_TA_DIR]) begin
        st_next.data = eng_rdata;
      end
    end
    st_next.rdata = SBB_RST_BYTE;
    if (cfg_rd_en && cfg_func == SBB_FUNC_OWN) begin
      case (cfg_addr)
        SBB_OFS_DATA: st_next.rdata = st_reg.data;
        SBB_OFS_INDEX: st_next.rdata = st_reg.index;
        SBB_OFS_TARGET: st_next.rdata = st_reg.target;
        SBB_OFS_CTRL: begin
          st_next.rdata[SBB_CS_SHORT] = st_reg.short_sel;
          st_next.rdata[SBB_CS_BUSY] = st_reg.busy;
          st_next.rdata[SBB_CS_DETECT] = st_reg.detect;
          st_next.rdata[SBB_CS_TEST] = st_reg.test;
          st_next.rdata[SBB_CS_ERR] = st_reg.err;
        end
        default: st_next.rdata = SBB_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_rdata = st_reg.rdata;

  // ==========================================================
  // serial engine on the link clock
  sbb_link_engine u_engine (
    .clk_link(clk_link),
    .reset(link_rst),
    .req_tgl(st_reg.req_tgl),
    .op_target(st_reg.target),
    .op_index(st_reg.index),
    .op_data(st_reg.data),
    .op_short(st_reg.short_sel),
    .op_test(st_reg.test),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_out(scl_out),
    .scl_oe_n(scl_oe_n),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .done_tgl(eng_done_tgl),
    .link_err(eng_err),
    .link_rdata(eng_rdata)
  );

  // ==========================================================
  // checks
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_launch_busy: assert property (
    (wr_own && cfg_addr == SBB_OFS_TARGET && !st_reg.busy)
    |=> st_reg.busy && st_reg.req_tgl != $past(st_reg.req_tgl))
    else $error("target write did not launch a transfer");
  a_target_store: assert property (
    (wr_own && cfg_addr == SBB_OFS_TARGET && !st_reg.busy)
    |=> st_reg.target == $past(cfg_wdata))
    else $error("target register not loaded");
  a_busy_done: assert property (
    (st_reg.busy && done_evt) |=> !st_reg.busy)
    else $error("busy not cleared on completion");
  a_busy_hold: assert property (
    (st_reg.busy && !done_evt) |=> st_reg.busy)
    else $error("busy dropped before completion");
  a_read_load: assert property (
    (done_evt && !eng_err && st_reg.target[0])
    |=> st_reg.data == $past(eng_rdata))
    else $error("read byte not loaded into data register");
  a_err_sticky: assert property (
    (st_reg.err && !(wr_own && cfg_addr == SBB_OFS_CTRL && cfg_wdata[1]))
    |=> st_reg.err)
    else $error("error flag dropped without write-back");
  a_err_set_wins: assert property (
    (done_evt && eng_err) |=> st_reg.err)
    else $error("error event lost");
  a_data_read: assert property (
    (cfg_rd_en && cfg_func == SBB_FUNC_OWN && cfg_addr == SBB_OFS_DATA)
    |=> cfg_rdata == $past(st_reg.data))
    else $error("data register read mismatch");
  a_other_func: assert property (
    (cfg_wr_en && cfg_func != SBB_FUNC_OWN && !done_evt)
    |=> st_reg.data == $past(st_reg.data)
        && st_reg.target == $past(st_reg.target))
    else $error("write to another function changed a register");
  a_reset_clear: assert property (disable iff (1'b0)
    reset |=> st_reg.data == 8'h00 && st_reg.index == 8'h00
              && st_reg.target == 8'h00)
    else $error("registers not cleared by global reset");
  a_link_hold: assert property (disable iff (1'b0)
    reset |=> !st_reg.link_up && st_reg.lrst_cnt == 6'h00)
    else $error("link engine not held in reset");
endmodule : sbb_serial_byte_access
`default_nettype wire

// File: sbb_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// behavioural two-wire memory device with a byte pointer
module sbb_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic short_mode,
  input wire logic stretch,
  output logic sda_low,
  output logic scl_low
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  int st;
  int cnt;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    sda_low = 1'b0;
    scl_low = 1'b0;
    ptr = 8'h00;
    st = 0;
    cnt = 0;
  end
  // start or repeated start, then stop
  always @(negedge sda) begin
    if (scl) begin
      st = 1;
      cnt = 0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      st = 0;
    end
  end
  always @(posedge scl) begin
    if (st != 0 && cnt < 8) begin
      if (st != 4) begin
        sh = {sh[6:0], sda};
      end
      cnt++;
    end
  end
  always @(negedge scl) begin
    if (st == 4) begin
      sda_low = (cnt < 8) ? !sh[7 - cnt] : 1'b0;
      if (cnt == 8) begin
        ptr++;
        st = 0;
      end
    end else if (st != 0 && cnt == 8) begin
      // only its own address is acknowledged
      sda_low = (st != 1) || (sh[7:1] == DEV_ADDR);
      st = sda_low ? st : 0;
      cnt = 9;
      if (stretch) begin
        scl_low = 1'b1;
        scl_low <= #3000 1'b0;
      end
    end else if (cnt == 9) begin
      sda_low = 1'b0;
      cnt = 0;
      case (st)
        1: st = sh[0] ? 4 : (short_mode ? 3 : 2);
        2: begin
          ptr = sh;
          st = 3;
        end
        3: begin
          mem[ptr] = sh;
          ptr++;
        end
        default: st = 0;
      endcase
      if (st == 4) begin
        sh = mem[ptr];
        sda_low = !sh[7];
      end
    end
  end
endmodule : sbb_eeprom_model
`default_nettype wire

// File: sbb_serial_byte_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sbb_serial_byte_access_tb;
  import sbb_pkg::*;
  localparam logic [6:0] DEV = 7'h50;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic reset = 1'b1;
  logic [2:0] cfg_func = 3'h0;
  logic [7:0] cfg_addr = 8'h00;
  logic cfg_wr_en = 1'b0;
  logic cfg_rd_en = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, sda_low, scl_low;
  logic short_mode = 1'b0;
  logic stretch = 1'b0;
  wire logic scl_w = scl_oe_n & !scl_low;
  wire logic sda_w = sda_oe_n & !sda_low;
  int n_fail = 0;
  int n_checks = 0;
  int ref_mem [256];
  logic [7:0] ref_ptr;
  always #5 clk_sys = ~clk_sys;
  always #80 clk_link = ~clk_link;
  sbb_serial_byte_access uut (.clk_sys(clk_sys), .reset(reset),
    .clk_link(clk_link), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
    .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n));
  sbb_eeprom_model #(.DEV_ADDR(DEV)) dev (.scl(scl_w), .sda(sda_w),
    .short_mode(short_mode), .stretch(stretch), .sda_low(sda_low),
    .scl_low(scl_low));
  // ==========================================================
  // register access and comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [2:0] f = 3'h0);
    @(posedge clk_sys);
    cfg_func <= f;
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr_en <= 1'b1;
    @(posedge clk_sys);
    cfg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    input logic [2:0] f = 3'h0);
    @(posedge clk_sys);
    cfg_func <= f;
    cfg_addr <= a;
    cfg_rd_en <= 1'b1;
    @(posedge clk_sys);
    cfg_rd_en <= 1'b0;
    #1 d = cfg_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rchk
  task automatic launch(input logic [7:0] tgt);
    logic [7:0] d;
    wr(SBB_OFS_TARGET, tgt);
    rd(SBB_OFS_CTRL, d);
    chk(d & 8'h20, 8'h20);
    for (int i = 0; i < 50000 && d[SBB_CS_BUSY] !== 1'b0; i++) begin
      rd(SBB_OFS_CTRL, d);
    end
    chk(d & 8'h20, 8'h00);
    chk({4'h0, scl_out, scl_oe_n, sda_out, sda_oe_n}, 8'h0F);
  endtask : launch
  task automatic long_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(SBB_OFS_DATA, d);
    wr(SBB_OFS_INDEX, idx);
    launch({DEV, 1'b0});
    ref_mem[idx] = d;
    ref_ptr = idx + 8'h01;
  endtask : long_wr
  task automatic long_rd(input logic [7:0] idx);
    wr(SBB_OFS_INDEX, idx);
    launch({DEV, 1'b1});
    rchk(SBB_OFS_DATA, 8'(ref_mem[idx]));
    ref_ptr = idx + 8'h01;
  endtask : long_rd
  task automatic do_reset;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (100) @(posedge clk_sys);
  endtask : do_reset
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    n_fail++;
    finish_test();
  end
  // ==========================================================
  // tests
  initial begin
    logic [7:0] d;
    int seed;
    int idxq[$];
    seed = $urandom(32'h536A);
    for (int i = 0; i < 256; i++) begin
      ref_mem[i] = i ^ 8'h5A;
    end
    do_reset();
    rchk(SBB_OFS_DATA, SBB_RST_BYTE);
    rchk(SBB_OFS_INDEX, SBB_RST_BYTE);
    rchk(SBB_OFS_TARGET, SBB_RST_BYTE);
    rchk(SBB_OFS_CTRL, 8'h08);
    wr(SBB_OFS_INDEX, 8'h3C, 3'h1);
    rd(SBB_OFS_INDEX, d, 3'h1);
    chk(d, 8'h00);
    rchk(SBB_OFS_INDEX, 8'h00);
    rchk(8'hA5, 8'h00);
    $display("test decode done");
    long_wr(8'($urandom), 8'($urandom));
    rchk(SBB_OFS_TARGET, {DEV, 1'b0});
    wr(SBB_OFS_CTRL, 8'h04);
    $display("test normal speed done");
    for (int i = 0; i < 3; i++) begin
      idxq.push_back(8'($urandom));
      long_wr(8'(idxq[i]), 8'($urandom));
    end
    foreach (idxq[i]) begin
      long_rd(8'(idxq[i]));
    end
    $display("test indexed done");
    wr(SBB_OFS_DATA, 8'hEE);
    launch({DEV ^ 7'h01, 1'b1});
    rchk(SBB_OFS_CTRL, 8'h06);
    rchk(SBB_OFS_DATA, 8'hEE);
    wr(SBB_OFS_CTRL, 8'h06);
    rchk(SBB_OFS_CTRL, 8'h04);
    $display("test error done");
    wr(SBB_OFS_CTRL, 8'h84);
    short_mode <= 1'b1;
    d = 8'($urandom);
    wr(SBB_OFS_DATA, d);
    launch({DEV, 1'b0});
    ref_mem[ref_ptr] = d;
    ref_ptr++;
    launch({DEV, 1'b1});
    rchk(SBB_OFS_DATA, 8'(ref_mem[ref_ptr]));
    wr(SBB_OFS_CTRL, 8'h04);
    short_mode <= 1'b0;
    $display("test short done");
    stretch <= 1'b1;
    long_rd(8'(idxq[0]));
    stretch <= 1'b0;
    $display("test stretch done");
    do_reset();
    rchk(SBB_OFS_DATA, SBB_RST_BYTE);
    rchk(SBB_OFS_INDEX, SBB_RST_BYTE);
    rchk(SBB_OFS_TARGET, SBB_RST_BYTE);
    rchk(SBB_OFS_CTRL, 8'h08);
    chk({4'h0, scl_out, scl_oe_n, sda_out, sda_oe_n}, 8'h0F);
    $display("test second reset done");
    finish_test();
  end
endmodule : sbb_serial_byte_access_tb
`default_nettype wire
